// *** hdl/dls_pkg.sv ***
// Purpose: Shared constants and types for the decoder local register port.
// Assumes: Local register port runs on the bus clock, 32-bit data lanes.
// Notes:   Offsets are byte addresses inside the 4 kB local window.

package dls_pkg;

	// ----------------------------------------------------------------
	// Window and address layout
	// ----------------------------------------------------------------
	localparam int          WIN_ADDR_LSB  = 12;
	localparam int          REG_ADDR_MSB  = 11;
	localparam int          REG_ADDR_LSB  = 2;
	localparam logic [11:0] OFS_DEV_STAT  = 12'h000;
	localparam logic [11:0] OFS_E_CROP    = 12'h00c;
	localparam logic [11:0] OFS_O_CROP    = 12'h08c;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_DEV_STAT  = 8'h00;
	localparam logic [7:0]  RST_CROP      = 8'h12;
	localparam logic [7:0]  RST_RW        = 8'h00;

	// ----------------------------------------------------------------
	// Device status bit positions
	// ----------------------------------------------------------------
	localparam int          BIT_PRESENT   = 7;
	localparam int          BIT_HLOCK     = 6;
	localparam int          BIT_FIELD     = 5;
	localparam int          BIT_FMT625    = 4;
	localparam int          BIT_RSVD      = 3;
	localparam int          BIT_PLL_UNLK  = 2;
	localparam int          BIT_LUMA_OVF  = 1;
	localparam int          BIT_CHROMA_OVF = 0;

	// ----------------------------------------------------------------
	// Status timing counts, in lines and fields
	// ----------------------------------------------------------------
	localparam logic [5:0]  NOSYNC_LINES  = 6'd31;
	localparam logic [5:0]  HLOCK_LINES   = 6'd32;
	localparam logic [5:0]  FMT_FIELDS    = 6'd32;

	// ----------------------------------------------------------------
	// Decoder status carrier
	// ----------------------------------------------------------------
	typedef struct packed {
		logic line_end;
		logic hsync_seen;
		logic hsync_on_time;
		logic field_even;
		logic field_end;
		logic field_625;
		logic pll_unlock;
		logic luma_ovf;
		logic chroma_ovf;
	} dls_dec_s;

endpackage

// *** hdl/dls_field_pair.sv ***
// Purpose: One register held as an even and an odd field copy.
// Assumes: Field indication is a level on the same clock.
// Notes:   The active copy follows the field indication with no delay.

`timescale 1ns/10ps
`default_nettype none

module dls_field_pair
	import dls_pkg::*;
#(
	parameter int         W     = 8,
	parameter logic [7:0] RST_V = 8'h00
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         wr_even,
	input  wire logic         wr_odd,
	input  wire logic [W-1:0] wdata,
	input  wire logic         field_even,
	output logic      [W-1:0] even_q,
	output logic      [W-1:0] odd_q,
	output logic      [W-1:0] active
);

	// ----------------------------------------------------------------
	// Copies and field switch
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			even_q <= RST_V[W-1:0];
			odd_q  <= RST_V[W-1:0];
		end else begin
			if (wr_even) even_q <= wdata;
			if (wr_odd)  odd_q  <= wdata;
		end
	end

	assign active = field_even ? even_q : odd_q;

	a_pair_switch: assert property (@(posedge clk) disable iff (!rst_n)
		wr_even |=> (active == (field_even ? $past(wdata) : odd_q)))
		else $error("Active field copy does not follow the field.");

endmodule

`default_nettype wire

// *** hdl/dls_local_regs.sv ***
// Purpose: Local register port and device status register of the decoder.
// Assumes: Bus target logic presents one data phase per cycle on LR_SEL.
// Notes:   Read data returns one clock after the data phase is taken.

`timescale 1ns/10ps
`default_nettype none

module dls_local_regs
	import dls_pkg::*;
#(
	parameter int AW = 32
) (
	input  wire logic          CLK,
	input  wire logic          RESET_N,
	input  wire logic [AW-1:WIN_ADDR_LSB] MEM_BASE,
	input  wire logic          LR_SEL,
	input  wire logic          LR_WR,
	input  wire logic [AW-1:2] LR_ADDR,
	input  wire logic [3:0]    LR_BE_N,
	input  wire logic [31:0]   LR_WDATA,
	output logic      [31:0]   LR_RDATA,
	output logic               LR_RVALID,
	input  wire dls_dec_s      DEC_STATUS,
	output logic      [7:0]    CROP_ACTIVE,
	output logic      [7:0]    STATUS_OUT
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	wire        win_hit;
	wire        acc;
	wire        wr_acc;
	wire        rd_acc;
	wire        lane0_en;
	wire [11:0] byte_ofs;
	wire        sel_stat;
	wire        sel_ecrop;
	wire        sel_ocrop;
	wire        wr_stat;
	wire        wr_ecrop;
	wire        wr_ocrop;

	assign win_hit   = (LR_ADDR[AW-1:WIN_ADDR_LSB] == MEM_BASE);
	assign acc       = LR_SEL & win_hit;
	assign wr_acc    = acc & LR_WR;
	assign rd_acc    = acc & ~LR_WR;
	assign byte_ofs  = {LR_ADDR[REG_ADDR_MSB:REG_ADDR_LSB], 2'b00};
	assign lane0_en  = ~LR_BE_N[0];
	assign sel_stat  = (byte_ofs == OFS_DEV_STAT);
	assign sel_ecrop = (byte_ofs == OFS_E_CROP);
	assign sel_ocrop = (byte_ofs == OFS_O_CROP);
	assign wr_stat   = wr_acc & sel_stat & lane0_en;
	assign wr_ecrop  = wr_acc & sel_ecrop & lane0_en;
	assign wr_ocrop  = wr_acc & sel_ocrop & lane0_en;

	// ----------------------------------------------------------------
	// Per-line sync event capture
	// ----------------------------------------------------------------
	logic       seen_q;
	logic       seen_d;
	logic       ontime_q;
	logic       ontime_d;
	wire        line_seen;
	wire        line_ontime;

	assign line_seen   = seen_q | DEC_STATUS.hsync_seen;
	assign line_ontime = ontime_q | DEC_STATUS.hsync_on_time;
	assign seen_d      = DEC_STATUS.line_end ? 1'b0 : line_seen;
	assign ontime_d    = DEC_STATUS.line_end ? 1'b0 : line_ontime;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			seen_q   <= 1'b0;
			ontime_q <= 1'b0;
		end else begin
			seen_q   <= seen_d;
			ontime_q <= ontime_d;
		end
	end

	// ----------------------------------------------------------------
	// Video present: count of lines without sync
	// ----------------------------------------------------------------
	logic [5:0] nosync_q;
	logic [5:0] nosync_d;
	wire        present;

	assign nosync_d = !DEC_STATUS.line_end ? nosync_q :
		line_seen ? 6'h00 :
		(nosync_q >= NOSYNC_LINES) ? NOSYNC_LINES :
		6'(nosync_q + 6'h01);
	assign present  = (nosync_q < NOSYNC_LINES);

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			nosync_q <= NOSYNC_LINES;
		end else begin
			nosync_q <= nosync_d;
		end
	end

	// ----------------------------------------------------------------
	// Horizontal lock with line hysteresis
	// ----------------------------------------------------------------
	logic       hlock_q;
	logic       hlock_d;
	logic [5:0] hl_cnt_q;
	logic [5:0] hl_cnt_d;
	wire        hl_differs;
	wire        hl_flip;

	assign hl_differs = (line_ontime != hlock_q);
	assign hl_flip    = DEC_STATUS.line_end & hl_differs &
		(hl_cnt_q == 6'(HLOCK_LINES - 6'h01));
	assign hl_cnt_d   = !DEC_STATUS.line_end ? hl_cnt_q :
		(!hl_differs || hl_flip) ? 6'h00 :
		6'(hl_cnt_q + 6'h01);
	assign hlock_d    = hl_flip ? ~hlock_q : hlock_q;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			hlock_q  <= 1'b0;
			hl_cnt_q <= 6'h00;
		end else begin
			hlock_q  <= hlock_d;
			hl_cnt_q <= hl_cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// Line format with field hysteresis
	// ----------------------------------------------------------------
	logic       fmt_q;
	logic       fmt_d;
	logic [5:0] fm_cnt_q;
	logic [5:0] fm_cnt_d;
	wire        fm_differs;
	wire        fm_flip;

	assign fm_differs = (DEC_STATUS.field_625 != fmt_q);
	assign fm_flip    = DEC_STATUS.field_end & fm_differs &
		(fm_cnt_q == 6'(FMT_FIELDS - 6'h01));
	assign fm_cnt_d   = !DEC_STATUS.field_end ? fm_cnt_q :
		(!fm_differs || fm_flip) ? 6'h00 :
		6'(fm_cnt_q + 6'h01);
	assign fmt_d      = fm_flip ? ~fmt_q : fmt_q;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			fmt_q    <= 1'b0;
			fm_cnt_q <= 6'h00;
		end else begin
			fmt_q    <= fmt_d;
			fm_cnt_q <= fm_cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// Field bit and sticky flags
	// ----------------------------------------------------------------
	logic       field_q;
	logic       pll_q;
	logic       pll_d;
	logic       luma_q;
	logic       luma_d;
	logic       chroma_q;
	logic       chroma_d;
	wire  [7:0] clr_mask;

	assign clr_mask = wr_stat ? LR_WDATA[7:0] : 8'h00;
	assign pll_d    = DEC_STATUS.pll_unlock |
		(pll_q & ~clr_mask[BIT_PLL_UNLK]);
	assign luma_d   = DEC_STATUS.luma_ovf |
		(luma_q & ~clr_mask[BIT_LUMA_OVF]);
	assign chroma_d = DEC_STATUS.chroma_ovf |
		(chroma_q & ~clr_mask[BIT_CHROMA_OVF]);

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			field_q  <= 1'b0;
			pll_q    <= 1'b0;
			luma_q   <= 1'b0;
			chroma_q <= 1'b0;
		end else begin
			field_q  <= DEC_STATUS.field_even;
			pll_q    <= pll_d;
			luma_q   <= luma_d;
			chroma_q <= chroma_d;
		end
	end

	// ----------------------------------------------------------------
	// Status word
	// ----------------------------------------------------------------
	wire [7:0] status_word;

	assign status_word = {present, hlock_q, field_q, fmt_q,
		1'b0, pll_q, luma_q, chroma_q};
	assign STATUS_OUT  = status_word;

	// ----------------------------------------------------------------
	// Field switched crop register
	// ----------------------------------------------------------------
	wire [7:0] ecrop;
	wire [7:0] ocrop;

	dls_field_pair #(
		.W     (8),
		.RST_V (RST_CROP)
	) u_crop (
		.clk        (CLK),
		.rst_n      (RESET_N),
		.wr_even    (wr_ecrop),
		.wr_odd     (wr_ocrop),
		.wdata      (LR_WDATA[7:0]),
		.field_even (field_q),
		.even_q     (ecrop),
		.odd_q      (ocrop),
		.active     (CROP_ACTIVE)
	);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	wire [7:0]  rd_byte;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic        rvalid_q;

	assign rd_byte = sel_stat  ? status_word :
		sel_ecrop ? ecrop :
		sel_ocrop ? ocrop :
		RST_RW;
	assign rdata_d = rd_acc ? {24'h000000, lane0_en ? rd_byte : 8'h00} :
		32'h00000000;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rdata_q  <= 32'h00000000;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= rd_acc;
		end
	end

	assign LR_RDATA  = rdata_q;
	assign LR_RVALID = rvalid_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	a_luma_sets: assert property (
		DEC_STATUS.luma_ovf |=> luma_q ##1 (luma_q || $past(clr_mask[BIT_LUMA_OVF])))
		else $error("Luma overflow flag did not set.");

	a_chroma_sets: assert property (
		DEC_STATUS.chroma_ovf |=> chroma_q)
		else $error("Chroma overflow flag did not set.");

	a_w1c_clears: assert property (
		wr_stat && LR_WDATA[BIT_CHROMA_OVF] && !DEC_STATUS.chroma_ovf |=> !chroma_q)
		else $error("Write of one did not clear the flag.");

	a_w0_keeps: assert property (
		wr_stat && !LR_WDATA[BIT_LUMA_OVF] && luma_q |=> luma_q)
		else $error("Write of zero changed a sticky flag.");

	a_upper_zero: assert property (
		rvalid_q |-> (LR_RDATA[31:8] == 24'h000000))
		else $error("Upper lanes returned nonzero data.");

	a_read_answer: assert property (
		rd_acc && sel_stat && lane0_en |=> LR_RVALID && (LR_RDATA[7:0] == $past(status_word)))
		else $error("Status read did not answer next cycle.");

	a_present_loss: assert property (
		DEC_STATUS.line_end && !line_seen && (nosync_q == 6'd30) |=> !STATUS_OUT[BIT_PRESENT])
		else $error("Video present did not clear after syncless lines.");

	a_hlock_flip: assert property (
		(hlock_q != $past(hlock_q)) |-> $past(DEC_STATUS.line_end && hl_cnt_q == 6'd31))
		else $error("Lock changed without full line hysteresis.");

	a_fmt_flip: assert property (
		(fmt_q != $past(fmt_q)) |-> $past(DEC_STATUS.field_end && fm_cnt_q == 6'd31))
		else $error("Format changed without full field hysteresis.");

	a_rsvd_zero: assert property (
		rvalid_q && $past(sel_stat) |-> !LR_RDATA[BIT_RSVD])
		else $error("Reserved status bit read nonzero.");

	a_pll_live: assert property (
		DEC_STATUS.pll_unlock |=> STATUS_OUT[BIT_PLL_UNLK])
		else $error("PLL bit not set while out of lock.");

	a_field_bit: assert property (
		1'b1 |=> (STATUS_OUT[BIT_FIELD] == $past(DEC_STATUS.field_even)))
		else $error("Field bit does not follow the decoded field.");

	a_crop_write: assert property (
		wr_ecrop |=> (ecrop == $past(LR_WDATA[7:0])))
		else $error("Even crop copy did not take the write.");

	a_unused_zero: assert property (
		rd_acc && !sel_stat && !sel_ecrop && !sel_ocrop |=> (LR_RDATA == 32'h00000000))
		else $error("Unused offset returned nonzero data.");

	a_outside_quiet: assert property (
		LR_SEL && !win_hit |=> !LR_RVALID)
		else $error("Access outside the window was answered.");

	c_hlock_rise: cover property ($rose(hlock_q));
	c_fmt_rise: cover property ($rose(fmt_q));
	c_flag_clear: cover property (chroma_q ##1 !chroma_q);
	c_crop_read: cover property (rd_acc && sel_ocrop ##1 LR_RVALID);
	c_present_loss: cover property ($fell(present));

endmodule

`default_nettype wire

// *** tb/dls_host_model.sv ***
// Purpose: Bus master model that issues local register data phases.
// Assumes: One data phase per request, launched after a rising edge.
// Notes:   Released address and data lines carry the inverse of the last value.
`timescale 1ns/10ps
`default_nettype none

module dls_host_model (
	input  wire logic        clk,
	output logic             sel,
	output logic             wr,
	output logic [31:2]      addr,
	output logic [3:0]       be_n,
	output logic [31:0]      wdata,
	input  wire logic [31:0] rdata,
	input  wire logic        rvalid
);
	initial begin
		sel = 1'b0;
		wr = 1'b0;
		addr = '0;
		be_n = 4'hf;
		wdata = '0;
	end

	// One data phase, then the answer edge one cycle after it is taken.
	task automatic xfer(input logic w, input logic [31:0] a, input logic [3:0] b,
		input logic [31:0] d, output logic [31:0] rd, output logic got);
		@(posedge clk);
		sel <= 1'b1;
		wr <= w;
		addr <= a[31:2];
		be_n <= b;
		wdata <= d;
		@(posedge clk);
		sel <= 1'b0;
		addr <= ~a[31:2];
		wdata <= ~d;
		@(posedge clk);
		rd = rdata;
		got = rvalid;
	endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the local register port and status.
// Assumes: Host model issues one data phase per request.
// Notes:   Decoder status pulses are driven by the bench.
`timescale 1ns/10ps
`default_nettype none

module tb;
	import dls_pkg::*;
	localparam logic [31:12] BASE = 20'h000a5;
	logic        clk;
	logic        reset_n;
	logic        sel;
	logic        wr;
	logic        rvalid;
	logic        got;
	logic [31:2] addr;
	logic [3:0]  be_n;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] rd;
	logic [7:0]  crop;
	logic [7:0]  stat;
	dls_dec_s    dec;
	int          mismatches;
	int          tests_run;
	int          cycles = 0;

	dls_local_regs i_dls_local_regs (.CLK(clk), .RESET_N(reset_n), .MEM_BASE(BASE),
		.LR_SEL(sel), .LR_WR(wr), .LR_ADDR(addr), .LR_BE_N(be_n), .LR_WDATA(wdata),
		.LR_RDATA(rdata), .LR_RVALID(rvalid), .DEC_STATUS(dec), .CROP_ACTIVE(crop),
		.STATUS_OUT(stat));
	dls_host_model i_dls_host_model (.clk(clk), .sel(sel), .wr(wr), .addr(addr),
		.be_n(be_n), .wdata(wdata), .rdata(rdata), .rvalid(rvalid));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic print_verdict();
		$display("tests_run %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask

	task automatic ticks(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wreg(input logic [11:0] o, input logic [31:0] d, input logic [3:0] b);
		i_dls_host_model.xfer(1'b1, {BASE, o}, b, d, rd, got);
	endtask

	task automatic rreg(input logic [11:0] o, input logic [31:0] e);
		i_dls_host_model.xfer(1'b0, {BASE, o}, 4'h0, 32'h0, rd, got);
		chk(32'(got), 32'h1, "read answer");
		chk(rd, e, "read data");
	endtask

	task automatic lines(input int n, input logic s, input logic o);
		repeat (n) begin
			@(posedge clk);
			dec.line_end <= 1'b1;
			dec.hsync_seen <= s;
			dec.hsync_on_time <= o;
			@(posedge clk);
			dec.line_end <= 1'b0;
			dec.hsync_seen <= 1'b0;
			dec.hsync_on_time <= 1'b0;
		end
		ticks(2);
	endtask

	task automatic fields(input int n);
		repeat (n) begin
			@(posedge clk);
			dec.field_end <= 1'b1;
			dec.field_625 <= 1'b1;
			@(posedge clk);
			dec.field_end <= 1'b0;
		end
		ticks(2);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		chk(32'(stat), 32'h0, "status after reset");
		rreg(OFS_DEV_STAT, 32'h0);
		rreg(OFS_E_CROP, 32'(RST_CROP));
		rreg(OFS_O_CROP, 32'(RST_CROP));
		$display("test reset done");
	endtask

	task automatic t_field();
		wreg(OFS_E_CROP, 32'h5a, 4'he);
		wreg(OFS_O_CROP, 32'ha5, 4'h0);
		@(posedge clk);
		dec.field_even <= 1'b1;
		ticks(2);
		chk(32'(stat[5]), 32'h1, "field even");
		chk(32'(crop), 32'h5a, "even copy active");
		@(posedge clk);
		dec.field_even <= 1'b0;
		ticks(2);
		chk(32'(stat[5]), 32'h0, "field odd");
		chk(32'(crop), 32'ha5, "odd copy active");
		$display("test field done");
	endtask

	task automatic t_lanes();
		i_dls_host_model.xfer(1'b0, {BASE, OFS_DEV_STAT}, 4'h0, 32'h0, rd, got);
		chk(32'(rd[31:8]), 32'h0, "upper lanes");
		wreg(OFS_E_CROP, 32'h33, 4'h1);
		rreg(OFS_E_CROP, 32'h5a);
		i_dls_host_model.xfer(1'b0, {BASE, OFS_E_CROP}, 4'h1, 32'h0, rd, got);
		chk(rd, 32'h0, "lane zero off read");
		rreg(12'h004, 32'h0);
		i_dls_host_model.xfer(1'b0, {BASE ^ 20'h1, 12'h0}, 4'h0, 32'h0, rd, got);
		chk(32'(got), 32'h0, "outside window");
		$display("test lanes done");
	endtask

	task automatic t_lines();
		lines(31, 1'b1, 1'b1);
		chk(32'(stat[7:6]), 32'h2, "present, no lock");
		lines(1, 1'b1, 1'b1);
		chk(32'(stat[7:6]), 32'h3, "lock after 32");
		wreg(OFS_DEV_STAT, 32'h0b8, 4'h0);
		chk(32'(stat[7:3]), 32'h18, "writes ignored");
		lines(30, 1'b0, 1'b0);
		chk(32'(stat[7:6]), 32'h3, "30 syncless");
		lines(1, 1'b0, 1'b0);
		chk(32'(stat[7:6]), 32'h1, "31 syncless");
		lines(1, 1'b0, 1'b0);
		chk(32'(stat[7:6]), 32'h0, "lock lost");
		$display("test lines done");
	endtask

	task automatic t_format();
		fields(31);
		chk(32'(stat[4]), 32'h0, "31 fields");
		fields(1);
		chk(32'(stat[4]), 32'h1, "32 fields");
		$display("test format done");
	endtask

	task automatic t_overflow();
		@(posedge clk);
		dec.luma_ovf <= 1'b1;
		dec.chroma_ovf <= 1'b1;
		@(posedge clk);
		dec.luma_ovf <= 1'b0;
		dec.chroma_ovf <= 1'b0;
		ticks(2);
		chk(32'(stat[1:0]), 32'h3, "sticky flags");
		wreg(OFS_DEV_STAT, 32'h0, 4'h0);
		chk(32'(stat[1:0]), 32'h3, "zero keeps");
		wreg(OFS_DEV_STAT, 32'h2, 4'h0);
		chk(32'(stat[1:0]), 32'h1, "luma cleared");
		wreg(OFS_DEV_STAT, 32'h1, 4'h0);
		chk(32'(stat[1:0]), 32'h0, "chroma cleared");
		$display("test overflow done");
	endtask

	task automatic t_pll();
		@(posedge clk);
		dec.pll_unlock <= 1'b1;
		ticks(2);
		chk(32'(stat[2]), 32'h1, "pll unlocked");
		wreg(OFS_DEV_STAT, 32'h4, 4'h0);
		chk(32'(stat[2]), 32'h1, "set wins");
		@(posedge clk);
		dec.pll_unlock <= 1'b0;
		for (int i = 0; i < 4 && stat[2] === 1'b1; i++)
			wreg(OFS_DEV_STAT, 32'h4, 4'h0);
		chk(32'(stat[2]), 32'h0, "pll clear stays");
		$display("test pll done");
	endtask

	task automatic t_rerst();
		wreg(OFS_O_CROP, 32'h3c, 4'h0);
		@(posedge clk);
		dec.luma_ovf <= 1'b1;
		dec.chroma_ovf <= 1'b1;
		@(posedge clk);
		dec.luma_ovf <= 1'b0;
		dec.chroma_ovf <= 1'b0;
		ticks(2);
		chk(32'(stat[1:0]), 32'h3, "flags before reset");
		reset_n <= 1'b0;
		ticks(2);
		chk(32'(stat), 32'h0, "status in second reset");
		reset_n <= 1'b1;
		rreg(OFS_O_CROP, 32'(RST_CROP));
		chk(32'(crop), 32'(RST_CROP), "crop after second reset");
		chk(32'(stat), 32'h0, "status after second reset");
		$display("test second reset done");
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			print_verdict();
		end
	end

	initial begin
		reset_n = 1'b0;
		dec = '0;
		mismatches = 0;
		tests_run = 0;
		repeat (6) @(posedge clk);
		chk(32'(stat), 32'h0, "status in reset");
		reset_n <= 1'b1;
		t_reset();
		t_field();
		t_lanes();
		t_lines();
		t_format();
		t_overflow();
		t_pll();
		t_rerst();
		print_verdict();
	end
endmodule
`default_nettype wire
